// >>> core/bcd_pkg.sv
// Constants shared by the three-phase gate-drive PWM block.
// Assumes a single 100 MHz system clock and a plain register port.
package bcd_pkg;

  // ==========================================================================
  // Register port geometry
  // ==========================================================================
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  CFG_ADDR    = 8'h00;  // pwm_config_reg
  localparam logic [7:0]  DT_ADDR     = 8'h04;  // dead-time register
  localparam logic [7:0]  STAT_ADDR   = 8'h08;  // status register

  // ==========================================================================
  // pwm_config_reg fields
  // ==========================================================================
  localparam int          CFG_BRK_LSB  = 0;     // brake_select_field, 2 bits
  localparam int          CFG_FW_ACT   = 2;     // 1: active freewheel, 0: diode
  localparam int          CFG_ALT_REC  = 3;     // alternating recirculation
  localparam int          CFG_OCP_EN   = 4;     // overcurrent triggers brake
  localparam int          CFG_WD_EN    = 5;     // watchdog fault triggers brake
  localparam int          CFG_W        = 6;
  localparam logic [5:0]  CFG_RESET    = 6'h00;

  // ==========================================================================
  // Dead-time register fields, counts in clock cycles
  // ==========================================================================
  localparam int          DT_W         = 8;
  localparam int          DEADTIME_RISING_LSB  = 0;
  localparam int          DEADTIME_FALLING_LSB  = 8;
  localparam logic [7:0]  DT_RESET     = 8'h0A;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int          ST_BRAKING   = 0;
  localparam int          ST_BRK_HIGH  = 1;     // side used by alternate brake
  localparam int          ST_LOW_MOD   = 2;     // second rotation, low side PWM
  localparam int          ST_HALL_BAD  = 3;
  localparam int          ST_SECT_LSB  = 4;     // 3-bit sector
  localparam int          ST_HIGH_LSB  = 8;     // live high gates
  localparam int          ST_LOW_LSB   = 12;    // live low gates

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MIN_DT_NS     = 50;   // hard floor on dead time
  localparam logic [7:0]  MIN_DT_CYC    =
    8'((MIN_DT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Brake modes (Gray along low, high, alternate, high-Z)
  // ==========================================================================
  typedef enum logic [1:0]
  {
    BCD_BRK_LOW  = 2'b00,
    BCD_BRK_HIGH = 2'b01,
    BCD_BRK_ALT  = 2'b11,
    BCD_BRK_HIZ  = 2'b10
  } bcd_brake_t;

endpackage

// >>> core/bcd_gate_ctrl.sv
// Three-phase 1PWM Hall commutation, braking and dead-time insertion.
// Assumes asynchronous pins for PWM, Hall, direction, brake and faults,
// and a register master on the same clock with one-cycle strobes.
//
// Overview of operation
// - Brake on pin low, overcurrent, watchdog fault
// - Brake pin active low, passed through the two-flop synchroniser first
// - Low-side brake: lows on, highs off
// - High-side brake: highs on, lows off
// - Alternate brake swaps side each event
// - High-Z brake: all six gates off
// - Brake mode chosen by brake select field
// - Brake fields writable live, applied at once
// - Opposing switches off first, then dead time
// - Brake released: PWM pass-through resumes
// - Brake pin honoured only after supply lockout
// - Internal and external brake sources wired-AND
// - Dead time between each phase's complementary gates
// - Separate rising and falling dead times
// - Fixed minimum dead time always enforced
// - Dead-time updates only at PWM edges
// - Diode freewheel: inverted PWM held low
// - Alternating recirculation uses twelve states
// - Low-modulated states wrap to first high state
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module bcd_gate_ctrl
  import bcd_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  // Controller pins
  input  wire logic                        pwm_duty_in,
  input  wire logic [2:0]                  hall_inputs,
  input  wire logic                        direction_in,
  // Brake sources, both open-drain onto one node
  input  wire logic                        brake_request_n,
  input  wire logic                        internal_brake_gpio_n,
  // Fault and supply status
  input  wire logic                        overcurrent_fault,
  input  wire logic                        watchdog_fault,
  input  wire logic                        logic_supply_ok,
  // Register port
  input  wire logic [bcd_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [bcd_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [bcd_pkg::DATA_W-1:0]  reg_rdata,
  // Gate outputs, bit 0 is phase A
  output logic      [2:0]                  high_gate_out,
  output logic      [2:0]                  low_gate_out
);
  import bcd_pkg::*;

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int SYN_W = 10;

  logic [SYN_W-1:0] syn_raw;
  logic [SYN_W-1:0] syn_meta;
  logic [SYN_W-1:0] syn_q;

  // Every pin is asynchronous, so all share the same two-flop chain
  assign syn_raw = {brake_request_n, internal_brake_gpio_n, pwm_duty_in,
                    hall_inputs, direction_in, overcurrent_fault,
                    watchdog_fault, logic_supply_ok};

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      syn_meta <= 10'h301;   // Brake pins idle high, supply assumed ok
      syn_q    <= 10'h301;
    end
    else
    begin
      syn_meta <= syn_raw;
      syn_q    <= syn_meta;
    end
  end

  wire       brk_pin_n  = syn_q[9];
  wire       brk_gpio_n = syn_q[8];
  wire       pwm_s      = syn_q[7];
  wire [2:0] hall_s     = syn_q[6:4];
  wire       dir_s      = syn_q[3];
  wire       ocp_s      = syn_q[2];
  wire       wd_s       = syn_q[1];
  wire       supply_s   = syn_q[0];

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [CFG_W-1:0] cfg;
  logic [DT_W-1:0]  deadtime_rising_sw;
  logic [DT_W-1:0]  deadtime_falling_sw;
  logic [DT_W-1:0]  deadtime_rising_act;
  logic [DT_W-1:0]  deadtime_falling_act;
  logic [DATA_W-1:0] status_word;

  wire wr_cfg = reg_wr && (reg_addr == CFG_ADDR);
  wire wr_dt  = reg_wr && (reg_addr == DT_ADDR);

  // Software copies; brake fields act on the very next cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg        <= CFG_RESET;
      deadtime_rising_sw <= DT_RESET;
      deadtime_falling_sw <= DT_RESET;
    end
    else
    begin
      if (wr_cfg)
        cfg <= reg_wdata[CFG_W-1:0];
      if (wr_dt)
      begin
        deadtime_rising_sw <= reg_wdata[DEADTIME_RISING_LSB +: DT_W];
        deadtime_falling_sw <= reg_wdata[DEADTIME_FALLING_LSB +: DT_W];
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == CFG_ADDR)  ? {{(DATA_W-CFG_W){1'b0}}, cfg} :
    (reg_addr == DT_ADDR)   ? {16'h0000, deadtime_falling_sw, deadtime_rising_sw} :
    (reg_addr == STAT_ADDR) ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  wire        fw_active = cfg[CFG_FW_ACT];
  wire        alt_rec   = cfg[CFG_ALT_REC];
  bcd_brake_t brk_mode;
  assign brk_mode = bcd_brake_t'(cfg[CFG_BRK_LSB +: 2]);

  // ==========================================================================
  // Dead-time shadow update
  // ==========================================================================
  logic pwm_q;
  wire  pwm_edge = pwm_s ^ pwm_q;

  // Swapping timings mid-interval could open a shoot-through gap
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pwm_q       <= 1'b0;
      deadtime_rising_act <= DT_RESET;
      deadtime_falling_act <= DT_RESET;
    end
    else
    begin
      pwm_q <= pwm_s;
      if (pwm_edge)
      begin
        deadtime_rising_act <= deadtime_rising_sw;
        deadtime_falling_act <= deadtime_falling_sw;
      end
    end
  end

  // Floor protects against a zero or tiny programmed value
  wire [DT_W-1:0] deadtime_rising_eff = (deadtime_rising_act < MIN_DT_CYC) ? MIN_DT_CYC : deadtime_rising_act;
  wire [DT_W-1:0] deadtime_falling_eff = (deadtime_falling_act < MIN_DT_CYC) ? MIN_DT_CYC : deadtime_falling_act;

  // ==========================================================================
  // Brake detection
  // ==========================================================================
  logic braking_q;
  logic brk_high_q;

  // Open-drain node: either source pulling low asserts it
  wire brk_node_n = brk_pin_n & brk_gpio_n;
  wire brk_trig   = (supply_s && !brk_node_n)
                  | (cfg[CFG_OCP_EN] && ocp_s)
                  | (cfg[CFG_WD_EN] && wd_s);
  wire brk_rise   = brk_trig && !braking_q;

  // Alternate mode flips side only on a fresh brake event
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      braking_q  <= 1'b0;
      brk_high_q <= 1'b1;
    end
    else
    begin
      braking_q <= brk_trig;
      if (brk_rise)
        brk_high_q <= ~brk_high_q;
    end
  end

  // Side used in alternate mode, valid from the event cycle on
  wire alt_high = brk_rise ? ~brk_high_q : brk_high_q;

  logic [2:0] brk_h;
  logic [2:0] brk_l;

  // Brake pattern follows the live mode field
  always_comb
  begin
    brk_h = 3'b000;
    brk_l = 3'b000;
    unique case (brk_mode)
      BCD_BRK_LOW:  brk_l = 3'b111;
      BCD_BRK_HIGH: brk_h = 3'b111;
      BCD_BRK_ALT:
      begin
        brk_h = alt_high ? 3'b111 : 3'b000;
        brk_l = alt_high ? 3'b000 : 3'b111;
      end
      BCD_BRK_HIZ:  ;
    endcase
  end

  // ==========================================================================
  // Hall commutation
  // ==========================================================================
  logic [2:0] sector;
  logic [2:0] sector_q;
  logic [2:0] hs_oh;
  logic [2:0] ls_oh;
  logic       low_mod_q;

  wire hall_bad = (hall_s == 3'b000) || (hall_s == 3'b111);

  // Sector order and phase pair for forward direction
  always_comb
  begin
    sector = 3'd0;
    hs_oh  = 3'b000;
    ls_oh  = 3'b000;
    unique case (hall_s)
      3'b101:
      begin
        sector = 3'd0;
        hs_oh  = 3'b001;
        ls_oh  = 3'b100;
      end
      3'b100:
      begin
        sector = 3'd1;
        hs_oh  = 3'b010;
        ls_oh  = 3'b100;
      end
      3'b110:
      begin
        sector = 3'd2;
        hs_oh  = 3'b010;
        ls_oh  = 3'b001;
      end
      3'b010:
      begin
        sector = 3'd3;
        hs_oh  = 3'b100;
        ls_oh  = 3'b001;
      end
      3'b011:
      begin
        sector = 3'd4;
        hs_oh  = 3'b100;
        ls_oh  = 3'b010;
      end
      3'b001:
      begin
        sector = 3'd5;
        hs_oh  = 3'b001;
        ls_oh  = 3'b010;
      end
      default: ;
    endcase
  end

  // Re-entering the first sector marks one electrical rotation
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sector_q  <= 3'd0;
      low_mod_q <= 1'b0;
    end
    else
    begin
      if (!hall_bad)
        sector_q <= sector;
      if (!alt_rec)
        low_mod_q <= 1'b0;
      else if (!hall_bad && sector == 3'd0 && sector_q != 3'd0)
        low_mod_q <= ~low_mod_q;
    end
  end

  // Reverse direction swaps which phase sources and which sinks
  wire [2:0] src_ph  = dir_s ? hs_oh : ls_oh;
  wire [2:0] snk_ph  = dir_s ? ls_oh : hs_oh;
  wire       comp    = fw_active & ~pwm_s;
  wire       mod_low = alt_rec & low_mod_q;

  // High modulated: sink low on; low modulated: source high on
  wire [2:0] run_h = mod_low ? (src_ph | (snk_ph & {3{comp}}))
                             : (src_ph & {3{pwm_s}});
  wire [2:0] run_l = mod_low ? (snk_ph & {3{pwm_s}})
                             : (snk_ph | (src_ph & {3{comp}}));

  // Final request: brake wins, then lockout and bad Hall float all
  wire       run_ok = supply_s && !hall_bad;
  wire [2:0] req_h  = braking_q ? brk_h : (run_ok ? run_h : 3'b000);
  wire [2:0] req_l  = braking_q ? brk_l : (run_ok ? run_l : 3'b000);

  // ==========================================================================
  // Per-phase dead-time insertion
  // ==========================================================================
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_phase
      logic [DT_W-1:0] idle_cnt;
      logic            last_low;

      // Turn-off is immediate; turn-on waits if the partner conducted last
      wire off_both = !high_gate_out[p] && !low_gate_out[p];
      wire on_h = req_h[p] && !req_l[p] && off_both &&
                  (!last_low || idle_cnt >= deadtime_rising_eff);
      wire on_l = req_l[p] && !req_h[p] && off_both &&
                  (last_low || idle_cnt >= deadtime_falling_eff);

      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          high_gate_out[p] <= 1'b0;
          low_gate_out[p]  <= 1'b0;
          idle_cnt         <= 8'hFF;
          last_low         <= 1'b0;
        end
        else
        begin
          high_gate_out[p] <= high_gate_out[p] ? req_h[p] : on_h;
          low_gate_out[p]  <= low_gate_out[p] ? req_l[p] : on_l;
          if (!off_both)
            idle_cnt <= 8'h01;
          else if (idle_cnt != 8'hFF)
            idle_cnt <= idle_cnt + 8'h01;
          if (high_gate_out[p])
            last_low <= 1'b0;
          else if (low_gate_out[p])
            last_low <= 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Status
  // ==========================================================================
  assign status_word = {16'h0000, 1'b0, low_gate_out, 1'b0, high_gate_out,
                        1'b0, sector_q, hall_bad, low_mod_q, brk_high_q,
                        braking_q};

endmodule

// >>> bench/bcd_gate_ctrl_asserts.sv
// Port-level checker for the gate-drive block.
// Assumes bind from the bench top; one clock, async active-low reset.
`timescale 1ns/1ps

module bcd_gate_ctrl_asserts
  import bcd_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // Pins
  input wire logic              pwm_duty_in,
  input wire logic [2:0]        hall_inputs,
  input wire logic              brake_request_n,
  input wire logic              internal_brake_gpio_n,
  input wire logic              overcurrent_fault,
  input wire logic              watchdog_fault,
  input wire logic              logic_supply_ok,
  // Register writes
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  // Gates
  input wire logic [2:0]        high_gate_out,
  input wire logic [2:0]        low_gate_out
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic [5:0] cfg;
  logic [7:0] bc;
  logic [2:0] pw;
  // Any enabled brake source; pin ignored under supply lockout
  wire brk = (overcurrent_fault && cfg[4]) || (watchdog_fault && cfg[5]) ||
             (!(brake_request_n && internal_brake_gpio_n) && logic_supply_ok);
  wire still = (pw == 3'h0) || (pw == 3'h7);

  // Shadow of the whole config register; brake age restarts on any write
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg <= 6'h00;
      bc  <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == CFG_ADDR)
        cfg <= reg_wdata[5:0];
      bc <= (!brk || reg_wr) ? 8'h00 : bc + {7'h00, bc != 8'hFF};
    end
  end

  // Recent PWM history, so brake timing is not masked by PWM edges
  always_ff @(posedge clk_sys)
  begin
    pw <= {pw[1:0], pwm_duty_in};
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  no_shoot_a: assert property ((high_gate_out & low_gate_out) == 3'h0)
    else $error("high and low gate on together");
  dead_low_a: assert property ($fell(high_gate_out[0]) |-> !low_gate_out[0] [*5])
    else $error("low gate on before minimum dead time");
  dead_high_a: assert property ($fell(low_gate_out[0]) |-> !high_gate_out[0] [*5])
    else $error("high gate on before minimum dead time");
  supply_off_a: assert property ((!logic_supply_ok && !brk) [*5] |->
    {high_gate_out, low_gate_out} == 6'h00)
    else $error("gates live under supply lockout");
  brake_low_a: assert property (bc >= 8'h04 && cfg[1:0] == BCD_BRK_LOW |->
    high_gate_out == 3'h0)
    else $error("high gate on in low-side brake");
  brake_high_a: assert property (bc >= 8'h04 && cfg[1:0] == BCD_BRK_HIGH |->
    low_gate_out == 3'h0)
    else $error("low gate on in high-side brake");
  brake_hiz_a: assert property (bc >= 8'h04 && cfg[1:0] == BCD_BRK_HIZ |->
    {high_gate_out, low_gate_out} == 6'h00)
    else $error("gate on in high-Z brake");
  hall_bad_a: assert property (((hall_inputs == 3'h0 || hall_inputs == 3'h7) && !brk)
    [*6] |-> {high_gate_out, low_gate_out} == 6'h00)
    else $error("gate on with invalid hall code");
  sync_hold_a: assert property ($fell(brake_request_n) && still && logic_supply_ok |=>
    $stable(high_gate_out) && $stable(low_gate_out))
    else $error("brake pin reached gates unsynchronised");

  brake_seen_c: cover property (bc == 8'h08);
  dead_seen_c: cover property ($fell(high_gate_out[0]));
  hall_seen_c: cover property (hall_inputs == 3'h7 && !brk);

endmodule

// >>> bench/bcd_ctrl_model.sv
// Controller model: PWM timer, Hall and direction pins, open-drain brake.
// Assumes the bench sets the commands just after a rising edge.
`timescale 1ns/1ps

module bcd_ctrl_model
#(
  parameter int HALF = 100
)
(
  // Clock
  input  wire logic       clk_sys,
  // Commands from the bench
  input  wire logic       run,
  input  wire logic       lvl,
  input  wire logic [2:0] hall,
  input  wire logic       dir,
  input  wire logic       brk,
  // Pins toward the block
  output logic            pwm_duty_in,
  output logic [2:0]      hall_inputs,
  output logic            direction_in,
  output logic            brake_request_n
);
  int cnt = 0;

  // Free-running timer when enabled, fixed level otherwise;
  // pins are unknown only before the first edge, while reset holds
  always @(posedge clk_sys)
  begin
    cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    pwm_duty_in <= run ? (cnt < HALF) : lvl;
    hall_inputs <= hall;
    direction_in <= dir;
    brake_request_n <= !brk;
  end

endmodule

// >>> bench/bcd_gate_ctrl_test.sv
// Bench top: register tasks, commutation, brake and dead-time sequences.
// Assumes the controller model and checker from bench/.
`timescale 1ns/1ps

module bcd_gate_ctrl_test;
  import bcd_pkg::*;
  logic        clk_sys = 0, rstn = 0, run = 0, lvl = 1, brk = 0, dir = 1;
  logic        internal_brake_gpio_n = 1, overcurrent_fault = 0;
  logic        watchdog_fault = 0, logic_supply_ok = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0]  hall = 3'h5, high_gate_out, low_gate_out, hall_inputs;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        pwm_duty_in, direction_in, brake_request_n;
  int          n_errors = 0, cmp_count = 0, i;
  // Hall code, expected high gates, expected low gates
  logic [8:0]  tab [6] = '{9'h14C, 9'h114, 9'h191, 9'h0A1, 9'h0E2, 9'h04A};
  logic [1:0]  md [3] = '{BCD_BRK_LOW, BCD_BRK_HIGH, BCD_BRK_HIZ};
  logic [5:0]  bx [3] = '{6'h07, 6'h38, 6'h00};

  bcd_ctrl_model bcd_ctrl_model_inst (.clk_sys, .run, .lvl, .hall, .dir, .brk,
    .pwm_duty_in, .hall_inputs, .direction_in, .brake_request_n);
  bcd_gate_ctrl bcd_gate_ctrl_inst (.clk_sys, .rstn, .pwm_duty_in, .hall_inputs,
    .direction_in, .brake_request_n, .internal_brake_gpio_n, .overcurrent_fault,
    .watchdog_fault, .logic_supply_ok, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .high_gate_out, .low_gate_out);

  initial forever #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    cmp(reg_rdata, e);
  endtask

  // Settle well past sync, dead time and output stages, then compare
  task automatic gates(input logic [5:0] e);
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp(32'({high_gate_out, low_gate_out}), 32'(e));
    @(posedge clk_sys);
  endtask

  // Idle cycles on phase A before the chosen gate turns on
  task automatic dead(input logic hi, input int e);
    int n;
    int k;
    for (k = 0; k < 900 && (hi ? low_gate_out[0] : high_gate_out[0]) !== 1'b1; k++)
      @(negedge clk_sys);
    for (; k < 900 && (high_gate_out[0] | low_gate_out[0]) !== 1'b0; k++)
      @(negedge clk_sys);
    for (n = 0; k < 900 && (hi ? high_gate_out[0] : low_gate_out[0]) !== 1'b1; k++)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (k >= 900)
    begin
      n_errors++;
      summarize();
    end
    cmp(32'(n >= e && n <= e + 2), 32'h1);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rreg(CFG_ADDR, 32'h0);
    rreg(DT_ADDR, 32'h0A0A);
    rreg(8'h0C, 32'h0);
    $display("registers done");
    // Both directions, PWM held high, diode freewheel; reverse swaps the pair
    for (i = 0; i < 12; i++)
    begin
      dir <= (i < 6);
      hall <= tab[i % 6][8:6];
      gates(i < 6 ? tab[i % 6][5:0] : {tab[i % 6][2:0], tab[i % 6][5:3]});
    end
    dir <= 1'b1;
    hall <= 3'h5;
    lvl <= 1'b0;
    gates(6'h04);
    wreg(CFG_ADDR, 32'h4);
    gates(6'h05);
    hall <= 3'h0;
    gates(6'h00);
    hall <= 3'h7;
    gates(6'h00);
    // Alternating recirculation, PWM low: second rotation drives high fully on
    hall <= 3'h5;
    wreg(CFG_ADDR, 32'h8);
    gates(6'h04);
    hall <= 3'h1;
    gates(6'h02);
    hall <= 3'h5;
    gates(6'h08);
    rreg(STAT_ADDR, 32'h0106);
    hall <= 3'h1;
    gates(6'h08);
    hall <= 3'h5;
    gates(6'h04);
    lvl <= 1'b1;
    $display("commutation done");
    for (i = 0; i < 3; i++)
    begin
      wreg(CFG_ADDR, {30'h0, md[i]});
      brk <= 1'b1;
      gates(bx[i]);
      brk <= 1'b0;
      gates(6'h0C);
    end
    wreg(CFG_ADDR, 32'h0);
    brk <= 1'b1;
    gates(6'h07);
    wreg(CFG_ADDR, 32'h1);
    gates(6'h38);
    brk <= 1'b0;
    wreg(CFG_ADDR, {30'h0, BCD_BRK_ALT});
    for (i = 0; i < 2; i++)
    begin
      brk <= 1'b1;
      gates(i ? 6'h38 : 6'h07);
      brk <= 1'b0;
      gates(6'h0C);
    end
    $display("brake modes done");
    wreg(CFG_ADDR, 32'h0);
    internal_brake_gpio_n <= 1'b0;
    gates(6'h07);
    internal_brake_gpio_n <= 1'b1;
    overcurrent_fault <= 1'b1;
    gates(6'h0C);
    wreg(CFG_ADDR, 32'h10);
    gates(6'h07);
    overcurrent_fault <= 1'b0;
    watchdog_fault <= 1'b1;
    wreg(CFG_ADDR, 32'h20);
    gates(6'h07);
    watchdog_fault <= 1'b0;
    logic_supply_ok <= 1'b0;
    brk <= 1'b1;
    gates(6'h00);
    logic_supply_ok <= 1'b1;
    gates(6'h07);
    brk <= 1'b0;
    $display("brake sources done");
    // Active freewheel with PWM running; settings land on a PWM edge
    wreg(CFG_ADDR, 32'h4);
    run <= 1'b1;
    wreg(DT_ADDR, 32'h0C14);
    repeat (250) @(posedge clk_sys);
    dead(1'b1, 20);
    dead(1'b0, 12);
    wreg(DT_ADDR, 32'h0102);
    repeat (250) @(posedge clk_sys);
    dead(1'b1, 5);
    dead(1'b0, 5);
    $display("dead time done");
    summarize();
  end

endmodule

bind bcd_gate_ctrl bcd_gate_ctrl_asserts bcd_gate_ctrl_asserts_inst (.clk_sys, .rstn,
  .pwm_duty_in, .hall_inputs, .brake_request_n, .internal_brake_gpio_n,
  .overcurrent_fault, .watchdog_fault, .logic_supply_ok, .reg_addr, .reg_wdata,
  .reg_wr, .high_gate_out, .low_gate_out);
